// file: design/gpio_port_data_lock_mux.v
// gpio port: output/input data, atomic set/clear, configuration lock, alternate function mux
// assumes a simple synchronous register port (select, write, byte enables) and pins sampled on clock
//
// Summary of operation
// - 16-bit read/write output, read-only input data
// - set/clear low bit one sets output bit
// - set/clear high bit one clears output bit
// - zero bits leave output bits unchanged
// - set wins over clear in one write
// - set/clear is one-shot; output data stays writable
// - one set/clear write updates bits atomically
// - lock covers six per-port configuration registers
// - key bit 16 sequence, mask bits constant
// - locked fields frozen until next reset
// - each mask bit freezes only its pin
// - lock sequence needs full word writes
// - one of sixteen channels, shared in/out
// - input mode: driver off, receiver on, pulls
// - pin levels sampled every clock into input
// - open drain: zero drives low, one floats
// - push-pull: zero drives low, one high
// - output data reads back last written value
// - alternate mode: peripheral enable and data drive
// - mode codes: input, output, alternate, analog
// - analog mode reads input bit as zero
// - byte, half-word and word accesses accepted
`include "gpio_port_defs.vh"
`timescale 1ns/10ps
`default_nettype none

// register map, byte offsets on bus_addr:
//   pin mode, output type, output speed and pull in the first four words
//   input data, output data, set/clear and lock in the next four words
//   alternate select low and high in the last two words
// unmapped offsets read as zero and ignore writes
// the input data word ignores writes; set/clear always reads as zero
//
// bus timing:
//   a request is taken at a rising edge with bus_sel high
//   a write lands in its register at that same edge
//   read data is registered and stands for one cycle only
//   bus_rdata returns to zero when no read is pending
//   back-to-back requests are fine; there are no wait states
//
// byte lanes:
//   every register honours bus_byte_en lane by lane
//   the lock word is the exception: a partial write aborts the key
//
// pin timing:
//   pin controls are registered from the configuration
//   so the pads follow a write one clock after the register
//   pin_in is taken as already synchronous to clock; a board
//   level that is not must be synchronised outside this block
//   the input word lags pin_in by one clock, a read by one more
//
// alternate functions:
//   one 4-bit select per pin picks both the transmit and receive channel
//   open-drain type applies in alternate mode as well
//   only the selected channel of a pin in alternate mode sees pin_in
//
// lock:
//   only a reset frees a locked pin; there is no unlock path
//   the mask of the last accepted key write is what locks
//   reads of the lock word during the sequence abort it
//   unless the sequence has reached its final key write
//   once locked, lock writes are ignored and the key reads one

module gpio_port_data_lock_mux #(
  parameter PINS = 16,
  parameter CHANNELS = 16
) (
  input wire clock,
  input wire rst,
  input wire bus_sel,
  input wire bus_write,
  input wire [5:0] bus_addr,
  input wire [3:0] bus_byte_en,
  input wire [31:0] bus_wdata,
  output reg [31:0] bus_rdata,
  input wire [PINS-1:0] pin_in,
  output reg [PINS-1:0] pin_out,
  output reg [PINS-1:0] pin_oe,
  output reg [PINS-1:0] pull_up_en,
  output reg [PINS-1:0] pull_down_en,
  output reg [PINS-1:0] receiver_en,
  output reg [2*PINS-1:0] speed_sel,
  input wire [PINS*CHANNELS-1:0] af_tx_data,
  input wire [PINS*CHANNELS-1:0] af_tx_en,
  output reg [PINS*CHANNELS-1:0] af_rx_data
);

  // lock state codes
  // the walk is idle, key1, key0, key1b and then done
  // done is left only through rst, which keeps a stray write
  // from ever unfreezing a pin that software relied on
  localparam [2:0] LK_IDLE = 3'h0;
  localparam [2:0] LK_KEY1 = 3'h1;
  localparam [2:0] LK_KEY0 = 3'h2;
  localparam [2:0] LK_KEY1B = 3'h3;
  localparam [2:0] LK_DONE = 3'h4;

  reg [31:0] pin_mode_select_reg, pin_mode_select_next;
  reg [15:0] output_type_select_reg, output_type_select_next;
  reg [31:0] output_speed_select_reg, output_speed_select_next;
  reg [31:0] pull_select_reg, pull_select_next;
  reg [31:0] alt_func_select_low_reg, alt_func_select_low_next;
  reg [31:0] alt_func_select_high_reg, alt_func_select_high_next;
  reg [15:0] output_data_reg, output_data_next;
  reg [15:0] input_data_reg;
  reg [15:0] lock_mask_reg, lock_mask_next;
  reg [2:0] lock_state_reg, lock_state_next;
  reg [31:0] rdata_next;

  wire wr = bus_sel & bus_write;
  wire rd = bus_sel & ~bus_write;
  wire [31:0] be_mask = {{8{bus_byte_en[3]}}, {8{bus_byte_en[2]}}, {8{bus_byte_en[1]}}, {8{bus_byte_en[0]}}};
  wire locked = (lock_state_reg == LK_DONE);
  wire [15:0] frozen = locked ? lock_mask_reg : `RST_HALF;
  wire [63:0] af_all = {alt_func_select_high_reg, alt_func_select_low_reg};

  // widen a per-pin lock mask to two bits per pin
  // used by mode, speed and pull, which all carry two-bit fields
  // so one mask bit must cover both bits of the same pin
  function [31:0] spread2;
    input [15:0] m;
    integer k;
    begin
      spread2 = `RST_WORD;
      for (k = 0; k < 16; k = k + 1) begin
        spread2[2*k] = m[k];
        spread2[2*k+1] = m[k];
      end
    end
  endfunction

  // widen eight pins of lock mask to four bits per pin
  function [31:0] spread4;
    input [7:0] m;
    integer k;
    begin
      spread4 = `RST_WORD;
      for (k = 0; k < 8; k = k + 1) begin
        spread4[4*k+:4] = {4{m[k]}};
      end
    end
  endfunction

  // byte-lane merge of a write, keeping bits held by the lock
  function [31:0] update;
    input [31:0] old;
    input [31:0] wd;
    input [31:0] lanes;
    input [31:0] hold;
    reg [31:0] en;
    begin
      en = lanes & ~hold;
      update = (old & ~en) | (wd & en);
    end
  endfunction

  // configuration writes; locked fields of each pin keep their value
  // a locked field is refused silently: no error, the old value stays
  // the output type word has a reserved top half that is never written
  // so it is merged in full width and cut back to its 16 live bits
  always @* begin : cfg_calc
    reg [31:0] type_wide;
    type_wide = update({16'h0000, output_type_select_reg}, bus_wdata, be_mask, {16'hFFFF, frozen});
    pin_mode_select_next = pin_mode_select_reg;
    output_type_select_next = output_type_select_reg;
    output_speed_select_next = output_speed_select_reg;
    pull_select_next = pull_select_reg;
    alt_func_select_low_next = alt_func_select_low_reg;
    alt_func_select_high_next = alt_func_select_high_reg;
    if (wr) begin
      case (bus_addr)
        `OFF_PIN_MODE: pin_mode_select_next = update(pin_mode_select_reg, bus_wdata, be_mask, spread2(frozen));
        `OFF_OUT_TYPE: output_type_select_next = type_wide[15:0];
        `OFF_OUT_SPEED: output_speed_select_next = update(output_speed_select_reg, bus_wdata, be_mask, spread2(frozen));
        `OFF_PULL: pull_select_next = update(pull_select_reg, bus_wdata, be_mask, spread2(frozen));
        `OFF_AF_LOW: alt_func_select_low_next = update(alt_func_select_low_reg, bus_wdata, be_mask,
          spread4(frozen[7:0]));
        `OFF_AF_HIGH: alt_func_select_high_next = update(alt_func_select_high_reg, bus_wdata, be_mask,
          spread4(frozen[15:8]));
        default: pin_mode_select_next = pin_mode_select_reg;
      endcase
    end
  end

  // output data: direct write or one-shot set/clear, all bits in one edge
  // set/clear never latches anything: after the edge it leaves no state
  // behind, so a later direct write is always obeyed as written
  // set is applied after clear so a bit asked for both ends up one
  always @* begin : out_data_calc
    reg [15:0] set_bits;
    reg [15:0] clr_bits;
    reg [31:0] out_wide;
    out_wide = update({16'h0000, output_data_reg}, bus_wdata, be_mask, 32'hFFFF_0000);
    set_bits = `RST_HALF;
    clr_bits = `RST_HALF;
    output_data_next = output_data_reg;
    if (wr && bus_addr == `OFF_OUT_DATA) begin
      output_data_next = out_wide[15:0];
    end else if (wr && bus_addr == `OFF_SET_CLEAR) begin
      set_bits = bus_wdata[15:0] & be_mask[15:0];
      clr_bits = bus_wdata[31:16] & be_mask[31:16];
      output_data_next = (output_data_reg & ~clr_bits) | set_bits;
    end
  end

  // lock sequence: word writes of key 1, 0, 1 with the same mask, then a read
  // any other access to the lock word in between sends it back to idle
  // a key-one write while waiting for key zero restarts with its mask,
  // which lets software retry without first clearing the machine
  // accesses to other registers do not disturb the sequence
  always @* begin
    lock_state_next = lock_state_reg;
    lock_mask_next = lock_mask_reg;
    if (bus_sel && bus_addr == `OFF_LOCK && !locked) begin
      if (!bus_write) begin
        lock_state_next = (lock_state_reg == LK_KEY1B) ? LK_DONE : LK_IDLE;
      end else if (bus_byte_en != `FULL_WORD) begin
        lock_state_next = LK_IDLE;
      end else begin
        lock_mask_next = bus_wdata[15:0];
        case (lock_state_reg)
          LK_IDLE: lock_state_next = bus_wdata[`LOCK_KEY_BIT] ? LK_KEY1 : LK_IDLE;
          LK_KEY1: lock_state_next = (!bus_wdata[`LOCK_KEY_BIT] && bus_wdata[15:0] == lock_mask_reg) ?
            LK_KEY0 : (bus_wdata[`LOCK_KEY_BIT] ? LK_KEY1 : LK_IDLE);
          LK_KEY0: lock_state_next = (bus_wdata[`LOCK_KEY_BIT] && bus_wdata[15:0] == lock_mask_reg) ?
            LK_KEY1B : LK_IDLE;
          default: lock_state_next = LK_IDLE;
        endcase
      end
    end
  end

  // read mux; answer is registered and appears one clock after the request
  // the lock word read uses the state before the read edge, so the read
  // that completes the sequence still shows the key bit low
  always @* begin
    rdata_next = `RST_WORD;
    case (bus_addr)
      `OFF_PIN_MODE: rdata_next = pin_mode_select_reg;
      `OFF_OUT_TYPE: rdata_next = {16'h0000, output_type_select_reg};
      `OFF_OUT_SPEED: rdata_next = output_speed_select_reg;
      `OFF_PULL: rdata_next = pull_select_reg;
      `OFF_IN_DATA: rdata_next = {16'h0000, input_data_reg};
      `OFF_OUT_DATA: rdata_next = {16'h0000, output_data_reg};
      `OFF_LOCK: rdata_next = {15'h0000, locked, lock_mask_reg};
      `OFF_AF_LOW: rdata_next = alt_func_select_low_reg;
      `OFF_AF_HIGH: rdata_next = alt_func_select_high_reg;
      default: rdata_next = `RST_WORD; // set/clear reads as zero, unmapped too
    endcase
  end

  // register state; only reset undoes the lock
  // reset is synchronous, so it must be held across at least one edge
  // for every register here to reach its reset value
  always @(posedge clock) begin
    if (rst) begin
      pin_mode_select_reg <= `RST_WORD;
      output_type_select_reg <= `RST_HALF;
      output_speed_select_reg <= `RST_WORD;
      pull_select_reg <= `RST_WORD;
      alt_func_select_low_reg <= `RST_WORD;
      alt_func_select_high_reg <= `RST_WORD;
      output_data_reg <= `RST_HALF;
      lock_mask_reg <= `RST_HALF;
      lock_state_reg <= LK_IDLE;
      bus_rdata <= `RST_WORD;
    end else begin
      pin_mode_select_reg <= pin_mode_select_next;
      output_type_select_reg <= output_type_select_next;
      output_speed_select_reg <= output_speed_select_next;
      pull_select_reg <= pull_select_next;
      alt_func_select_low_reg <= alt_func_select_low_next;
      alt_func_select_high_reg <= alt_func_select_high_next;
      output_data_reg <= output_data_next;
      lock_mask_reg <= lock_mask_next;
      lock_state_reg <= lock_state_next;
      bus_rdata <= rd ? rdata_next : `RST_WORD;
    end
  end

  // pin side: drivers, pulls, receiver and alternate routing, all registered
  // registering costs one clock of latency but keeps the pads glitch free
  // while a mode word is rewritten lane by lane
  // input and analog modes leave the driver off; analog also drops
  // the pulls and the receiver so the input word reads zero
  always @(posedge clock) begin : pin_side
    integer i;
    integer c;
    reg [1:0] md;
    reg [3:0] ch;
    reg drv;
    reg dat;
    if (rst) begin
      pin_out <= `RST_HALF;
      pin_oe <= `RST_HALF;
      pull_up_en <= `RST_HALF;
      pull_down_en <= `RST_HALF;
      receiver_en <= `RST_HALF;
      speed_sel <= `RST_WORD;
      input_data_reg <= `RST_HALF;
      af_rx_data <= {PINS*CHANNELS{1'b0}};
    end else begin
      speed_sel <= output_speed_select_reg;
      for (i = 0; i < PINS; i = i + 1) begin
        md = pin_mode_select_reg[2*i+:2];
        ch = af_all[4*i+:4];
        drv = 1'b0;
        dat = 1'b0;
        case (md)
          `MODE_OUTPUT: begin
            drv = 1'b1;
            dat = output_data_reg[i];
          end
          `MODE_ALT: begin
            drv = af_tx_en[i*CHANNELS+ch];
            dat = af_tx_data[i*CHANNELS+ch];
          end
          default: drv = 1'b0;
        endcase
        if (output_type_select_reg[i]) begin
          pin_out[i] <= 1'b0;
          pin_oe[i] <= drv & ~dat;
        end else begin
          pin_out[i] <= dat;
          pin_oe[i] <= drv;
        end
        // analog turns off pulls and forces the receiver to zero
        pull_up_en[i] <= (md != `MODE_ANALOG) && pull_select_reg[2*i+:2] == `PULL_UP;
        pull_down_en[i] <= (md != `MODE_ANALOG) && pull_select_reg[2*i+:2] == `PULL_DOWN;
        receiver_en[i] <= (md != `MODE_ANALOG);
        input_data_reg[i] <= (md == `MODE_ANALOG) ? 1'b0 : pin_in[i];
        for (c = 0; c < CHANNELS; c = c + 1) begin
          af_rx_data[i*CHANNELS+c] <= (md == `MODE_ALT) && (ch == c) && pin_in[i];
        end
      end
    end
  end

endmodule // gpio_port_data_lock_mux

`default_nettype wire

// file: inc/gpio_port_defs.vh
// constants for the gpio port block: register offsets, field codes, reset values
// assumes word-aligned byte offsets on a 6-bit register address
`ifndef GPIO_PORT_DEFS_VH
`define GPIO_PORT_DEFS_VH

// register byte offsets
`define OFF_PIN_MODE 6'h00
`define OFF_OUT_TYPE 6'h04
`define OFF_OUT_SPEED 6'h08
`define OFF_PULL 6'h0C
`define OFF_IN_DATA 6'h10
`define OFF_OUT_DATA 6'h14
`define OFF_SET_CLEAR 6'h18
`define OFF_LOCK 6'h1C
`define OFF_AF_LOW 6'h20
`define OFF_AF_HIGH 6'h24

// pin mode field codes
`define MODE_INPUT 2'h0
`define MODE_OUTPUT 2'h1
`define MODE_ALT 2'h2
`define MODE_ANALOG 2'h3

// pull field codes
`define PULL_UP 2'h1
`define PULL_DOWN 2'h2

// lock register layout
`define LOCK_KEY_BIT 16
`define FULL_WORD 4'hF

// reset values
`define RST_WORD 32'h0000_0000
`define RST_HALF 16'h0000

`endif

// file: tb/pad_model.sv
// board pads: design drive, else outside source, else pulls
// a bare floating pin shows the inverse of its last level
`timescale 1ns/10ps
`default_nettype none
module pad_model (
  input wire logic clock,
  input wire logic [15:0] pin_out, pin_oe, pull_up_en, pull_down_en, ext_en, ext_val,
  output logic [15:0] pin_in
);
  logic [15:0] last_reg = 16'h0000;
  // an unpulled float must not keep a value the simulator picked
  always_comb for (int i = 0; i < 16; i++)
    pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
      pull_up_en[i] ? 1'b1 : pull_down_en[i] ? 1'b0 : ~last_reg[i];
  always @(posedge clock) last_reg <= pin_in;
endmodule // pad_model
`default_nettype wire

// file: tb/gpio_port_sva.sv
// checker: read timing, pad control relations, lock key
// bound to the port block, sees its ports only
`include "gpio_port_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module gpio_port_sva (
  input wire logic clock, rst, bus_sel, bus_write,
  input wire logic [5:0] bus_addr,
  input wire logic [3:0] bus_byte_en,
  input wire logic [31:0] bus_wdata, bus_rdata, speed_sel,
  input wire logic [15:0] pin_in, pin_oe, pull_up_en, pull_down_en, receiver_en,
  input wire logic [255:0] af_rx_data
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire rd = bus_sel && !bus_write;
  logic lock_rd_q, locked_q;
  // remembers a seen lock so later key reads can be judged
  always @(posedge clock) begin
    if (rst) begin
      lock_rd_q <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      lock_rd_q <= rd && bus_addr == `OFF_LOCK;
      if (lock_rd_q && bus_rdata[16]) locked_q <= 1'b1;
    end
  end
  a_rdata_idle: assert property (!rd |=> bus_rdata == 32'h0) else $error("read data not idle");
  a_setclr_rd: assert property (rd && bus_addr == `OFF_SET_CLEAR |=> bus_rdata == 32'h0)
    else $error("set/clear read not zero");
  a_idr_sample: assert property (rd && bus_addr == `OFF_IN_DATA && &receiver_en && $stable(receiver_en)
    |=> bus_rdata[15:0] == $past(pin_in, 2)) else $error("input data not sampled pins");
  a_pull_excl: assert property ((pull_up_en & pull_down_en) == 16'h0) else $error("both pulls on");
  a_analog_quiet: assert property ((~receiver_en & (pin_oe | pull_up_en | pull_down_en)) == 16'h0)
    else $error("analog pin driven or pulled");
  a_af_onehot: assert property ($onehot0(af_rx_data[15:0]) && $onehot0(af_rx_data[255:240]))
    else $error("several channels fed");
  a_key_sticky: assert property (lock_rd_q && locked_q |-> bus_rdata[16]) else $error("key bit dropped");
  a_speed_copy: assert property (bus_sel && bus_write && bus_addr == `OFF_OUT_SPEED && bus_byte_en == 4'hF
    && !locked_q |=> ##1 speed_sel == $past(bus_wdata, 2)) else $error("speed not copied");
  c_locked: cover property (lock_rd_q && bus_rdata[16]);
  c_idr: cover property (rd && bus_addr == `OFF_IN_DATA);
  c_af: cover property (|af_rx_data);
endmodule // gpio_port_sva
`default_nettype wire

// file: tb/gpio_port_data_lock_mux_tb.sv
// bench: register tasks, set/clear, pad modes, alternate mux, lock
// pads come from pad_model; checker bound at the foot
`include "gpio_port_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module gpio_port_data_lock_mux_tb;
  logic clock = 1'b0, rst = 1'b1, bus_sel = 1'b0, bus_write = 1'b0;
  logic [5:0] bus_addr = 6'h00;
  logic [3:0] bus_byte_en = 4'h0;
  logic [31:0] bus_wdata = 32'h0, bus_rdata, speed_sel, r;
  logic [15:0] pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, receiver_en, ext_en = 16'h0, ext_val = 16'h0;
  logic [255:0] af_tx_data = 256'h0, af_tx_en = 256'h0, af_rx_data;
  int bad_count = 0, num_checks = 0, cyc = 0;
  gpio_port_data_lock_mux gpio_port_data_lock_mux_inst (.clock, .rst, .bus_sel, .bus_write, .bus_addr,
    .bus_byte_en, .bus_wdata, .bus_rdata, .pin_in, .pin_out, .pin_oe, .pull_up_en, .pull_down_en,
    .receiver_en, .speed_sel, .af_tx_data, .af_tx_en, .af_rx_data);
  pad_model pad_model_inst (.clock, .pin_out, .pin_oe, .pull_up_en, .pull_down_en, .ext_en, .ext_val, .pin_in);
  initial forever #20 clock = ~clock;
  // hang guard, well above the sequence length
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  task automatic wr(input [5:0] a, input [31:0] d, input [3:0] be = 4'hF);
    @(posedge clock);
    bus_sel <= 1'b1;
    bus_write <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    bus_byte_en <= be;
    @(posedge clock);
    bus_sel <= 1'b0;
  endtask
  task automatic rd(input [5:0] a, output [31:0] d);
    @(posedge clock);
    bus_sel <= 1'b1;
    bus_write <= 1'b0;
    bus_addr <= a;
    @(posedge clock);
    bus_sel <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic chk(input string n, input [31:0] s, input [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input string n, input [5:0] a, input [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(n, v, e);
  endtask
  // pins follow registers one cycle late; let that land
  task settle;
    repeat (3) @(posedge clock);
    #1;
  endtask
  // middle word varies to abort or complete the sequence
  task automatic lockseq(input [31:0] mid, input [3:0] be, output [31:0] d);
    wr(`OFF_LOCK, 32'h0001_0001);
    wr(`OFF_LOCK, mid, be);
    wr(`OFF_LOCK, 32'h0001_0001);
    rd(`OFF_LOCK, d);
    rd(`OFF_LOCK, d);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rchk("mode", `OFF_PIN_MODE, 32'h0);
    rchk("setclr", `OFF_SET_CLEAR, 32'h0);
    rchk("unmapped", 6'h28, 32'h0);
    wr(`OFF_OUT_DATA, 32'h0000_00F0);
    wr(`OFF_SET_CLEAR, 32'h000F_00F1);
    rchk("odr", `OFF_OUT_DATA, 32'h0000_00F1);
    wr(`OFF_SET_CLEAR, 32'h0);
    rchk("odr", `OFF_OUT_DATA, 32'h0000_00F1);
    wr(`OFF_SET_CLEAR, 32'hFFFF_FFFF, 4'h4);
    rchk("odr", `OFF_OUT_DATA, 32'h0);
    wr(`OFF_OUT_DATA, 32'h0000_1234);
    rchk("odr", `OFF_OUT_DATA, 32'h0000_1234);
    wr(`OFF_SET_CLEAR, 32'h0200_00C1);
    rchk("odr", `OFF_OUT_DATA, 32'h0000_10F5);
    wr(`OFF_PIN_MODE, 32'h5555_5555);
    wr(`OFF_OUT_SPEED, 32'h1234_5678);
    settle;
    chk("oe", pin_oe, 32'h0000_FFFF);
    chk("out", pin_out, 32'h0000_10F5);
    chk("speed", speed_sel, 32'h1234_5678);
    wr(`OFF_IN_DATA, 32'h0);
    rchk("idr", `OFF_IN_DATA, 32'h0000_10F5);
    wr(`OFF_PULL, 32'h5555_5555);
    wr(`OFF_OUT_TYPE, 32'h0000_FFFF);
    settle;
    chk("od_out", pin_out, 32'h0);
    chk("od_oe", pin_oe, 32'h0000_EF0A);
    chk("pu", pull_up_en, 32'h0000_FFFF);
    rchk("idr", `OFF_IN_DATA, 32'h0000_10F5);
    wr(`OFF_PIN_MODE, 32'h0);
    wr(`OFF_PULL, 32'hAAAA_AAAA);
    settle;
    chk("in_oe", pin_oe, 32'h0);
    chk("pd", pull_down_en, 32'h0000_FFFF);
    rchk("idr", `OFF_IN_DATA, 32'h0);
    @(posedge clock);
    ext_en <= 16'hFFFF;
    ext_val <= 16'hA5C3;
    settle;
    rchk("idr", `OFF_IN_DATA, 32'h0000_A5C3);
    wr(`OFF_PIN_MODE, 32'hFFFF_FFFF);
    settle;
    chk("rx_en", receiver_en, 32'h0);
    rchk("idr", `OFF_IN_DATA, 32'h0);
    ext_en <= 16'h0;
    af_tx_data[3] <= 1'b1;
    af_tx_en[3] <= 1'b1;
    wr(`OFF_PULL, 32'h0);
    wr(`OFF_OUT_TYPE, 32'h0);
    wr(`OFF_AF_LOW, 32'h0000_0003);
    wr(`OFF_PIN_MODE, 32'h0000_0002);
    settle;
    chk("af_pin", {pin_oe[0], pin_out[0]}, 32'h3);
    chk("af_rx", af_rx_data[15:0], 32'h0000_0008);
    lockseq(32'h0000_0002, 4'hF, r);
    chk("key", r[16], 32'h0);
    lockseq(32'h0000_0001, 4'h3, r);
    chk("key", r[16], 32'h0);
    lockseq(32'h0000_0001, 4'hF, r);
    chk("key", r[16], 32'h1);
    wr(`OFF_PIN_MODE, 32'h5555_5555);
    rchk("mode", `OFF_PIN_MODE, 32'h5555_5556);
    wr(`OFF_AF_LOW, 32'h0);
    rchk("af_low", `OFF_AF_LOW, 32'h0000_0003);
    wr(`OFF_LOCK, 32'h0);
    rd(`OFF_LOCK, r);
    chk("key", r[16], 32'h1);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rchk("lock", `OFF_LOCK, 32'h0);
    rchk("mode", `OFF_PIN_MODE, 32'h0);
    tally_and_finish;
  end
endmodule // gpio_port_data_lock_mux_tb
bind gpio_port_data_lock_mux gpio_port_sva gpio_port_sva_inst (.clock, .rst, .bus_sel, .bus_write, .bus_addr,
  .bus_byte_en, .bus_wdata, .bus_rdata, .speed_sel, .pin_in, .pin_oe, .pull_up_en, .pull_down_en,
  .receiver_en, .af_rx_data);
`default_nettype wire
